// ==== spmh_pkg.sv ====
// Package of constants and carrier types for the serial port handshake block
package spmh_pkg;

	localparam int        SPMH_SYNC_STAGES = 2;
	localparam int        SPMH_BUF_DEPTH   = 2;
	localparam int        SPMH_DATA_W      = 8;
	localparam int        SPMH_CNT_W       = 16;
	localparam logic      SPMH_IDLE_LEVEL  = 1'b1;
	localparam logic [15:0] SPMH_DIV_RESET = 16'h0000;
	localparam logic [15:0] SPMH_DIV_DEFAULT = 16'h0010;

	typedef logic [SPMH_DATA_W-1:0] spmh_byte_t;

	// Handshake lines from the modem
	typedef struct packed {
		logic cts;
		logic dsr;
		logic dcd;
	} spmh_dce_hs_t;

	// Terminal-side configuration
	typedef struct packed {
		logic       sync_mode;
		logic       local_clk;
		logic       rts_req;
		logic       dtr_req;
		logic       ctrl_send;
		logic [15:0] clk_div;
	} spmh_cfg_t;

	typedef enum logic [1:0] {
		SPMH_TX_IDLE,
		SPMH_TX_SHIFT,
		SPMH_TX_DRAIN
	} spmh_tx_state_t;

endpackage

// ==== spmh_buf.sv ====
// Two-entry valid/ready buffer for transmit bytes
module spmh_buf
	import spmh_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Fill side
	input  wire logic       in_valid,
	output logic            in_ready,
	input  wire spmh_byte_t in_data,
	// Drain side
	output logic            out_valid,
	input  wire logic       out_ready,
	output spmh_byte_t      out_data
);

	spmh_byte_t mem_q [SPMH_BUF_DEPTH];
	spmh_byte_t mem_d [SPMH_BUF_DEPTH];
	logic       wp_q, wp_d, rp_q, rp_d;
	logic [1:0] cnt_q, cnt_d;
	logic       push, pop, rdy_q, rdy_d;

	assign push      = in_valid && rdy_q;
	assign pop       = out_valid && out_ready;
	assign in_ready  = rdy_q;
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rp_q];

	always_comb
	begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push)
		begin
			mem_d[wp_q] = in_data;
			wp_d        = ~wp_q;
		end
		if (pop)
			rp_d = ~rp_q;
		if (push && !pop)
			cnt_d = cnt_q + 2'h1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'h1;
		// Registered not-full flag
		rdy_d = (cnt_d != 2'h2);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
			rdy_q    <= 1'b0;
		end
		else
		begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
	end

endmodule

// ==== spmh_port.sv ====
// Terminal-side serial port with modem handshake and sync clocks
// What this block does
// - Send only with request, clear, ready, carrier asserted, or with control send set
// - Raising request puts modem in transmit
// - Dropping request lets current character finish
// - Clear alone: no payload, control only
// - No data sent while clear is low unless control send is set
// - Terminal ready output controls line switching
// - Receive serial data from modem
// - Transmit bits change on modem tx rising, or on local clock rising when local clock is used
// - Sample receive data on rx falling
// - Local clock only in sync when requested
// - Otherwise in sync mode terminal clock echoes modem clock; in async it is held low
// - Terminal clock falls mid transmitted bit
module spmh_port
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Configuration
	input  wire spmh_pkg::spmh_cfg_t cfg,
	// Transmit stream
	input  wire logic          tx_valid,
	output logic               tx_ready,
	input  wire spmh_pkg::spmh_byte_t tx_data,
	// Receive stream
	output logic               rx_valid,
	output spmh_pkg::spmh_byte_t rx_data,
	// Status
	output spmh_pkg::spmh_dce_hs_t hs_status,
	output logic               link_ok,
	// Modem pins
	output logic               txd,
	input  wire logic          rxd,
	output logic               rts,
	output logic               dtr,
	input  wire logic          cts,
	input  wire logic          dsr,
	input  wire logic          dcd,
	input  wire logic          dce_tx_clock,
	input  wire logic          dce_rx_clock,
	output logic               dte_terminal_clock,
	output logic               dte_terminal_clock_oe
);
	import spmh_pkg::*;

	// ***************************************
	// Input synchronisers
	// ***************************************
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] raw, s1_q, s2_q, s3_q;
	assign raw = {cts, dsr, dcd, rxd, dce_tx_clock, dce_rx_clock};
	for (genvar gi = 0; gi < NSYNC; gi++)
	begin : g_sync
		always_ff @(posedge clk_sys or negedge rst_n)
		begin
			if (!rst_n)
			begin
				s1_q[gi] <= 1'b0;
				s2_q[gi] <= 1'b0;
				s3_q[gi] <= 1'b0;
			end
			else
			begin
				s1_q[gi] <= raw[gi];
				s2_q[gi] <= s1_q[gi];
				s3_q[gi] <= s2_q[gi];
			end
		end
	end

	logic cts_s, dsr_s, dcd_s, rxd_s, txc_s, rxc_s;
	logic txc_rise, rxc_fall;
	assign {cts_s, dsr_s, dcd_s, rxd_s, txc_s, rxc_s} = s2_q;
	assign txc_rise = cfg.sync_mode && s2_q[1] && !s3_q[1];
	assign rxc_fall = cfg.sync_mode && !s2_q[0] && s3_q[0];

	// ***************************************
	// Local bit clock divider
	// ***************************************
	logic [15:0] div_q, div_d;
	logic        lclk_q, lclk_d;
	logic        lrise, lfall;
	always_comb
	begin
		div_d  = div_q + 16'h0001;
		lclk_d = lclk_q;
		lrise  = 1'b0;
		lfall  = 1'b0;
		if (!cfg.sync_mode || !cfg.local_clk)
			div_d = SPMH_DIV_RESET;
		else if (div_q >= cfg.clk_div)
		begin
			div_d  = SPMH_DIV_RESET;
			lclk_d = ~lclk_q;
			lrise  = ~lclk_q;
			lfall  = lclk_q;
		end
	end

	// ***************************************
	// Transmit buffer and shifter
	// ***************************************
	logic       b_valid, b_ready;
	spmh_byte_t b_data;
	spmh_buf u_buf (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (b_valid),
		.out_ready (b_ready),
		.out_data  (b_data)
	);

	spmh_tx_state_t st_q, st_d;
	spmh_byte_t     sh_q, sh_d;
	logic [3:0]     bit_q, bit_d;
	logic           txd_q, txd_d;
	logic           bit_edge, may_send;
	assign bit_edge = cfg.local_clk ? lrise : txc_rise;
	assign may_send = cfg.ctrl_send || (cfg.rts_req && cts_s && dcd_s && dsr_s);

	always_comb
	begin
		st_d    = st_q;
		sh_d    = sh_q;
		bit_d   = bit_q;
		txd_d   = txd_q;
		b_ready = 1'b0;
		case (st_q)
			SPMH_TX_IDLE:
			begin
				txd_d = SPMH_IDLE_LEVEL;
				if (cfg.sync_mode && may_send && b_valid && bit_edge)
				begin
					b_ready = 1'b1;
					sh_d    = b_data >> 1;
					txd_d   = b_data[0];
					bit_d   = 4'h1;
					st_d    = SPMH_TX_SHIFT;
				end
			end
			SPMH_TX_SHIFT:
				if (bit_edge)
				begin
					if (bit_q == 4'(SPMH_DATA_W))
					begin
						txd_d = SPMH_IDLE_LEVEL;
						st_d  = SPMH_TX_IDLE;
					end
					else
					begin
						txd_d = sh_q[0];
						sh_d  = sh_q >> 1;
						bit_d = bit_q + 4'h1;
					end
				end
			default:
				st_d = SPMH_TX_IDLE;
		endcase
		if (!cfg.sync_mode)
		begin
			st_d  = SPMH_TX_IDLE;
			txd_d = SPMH_IDLE_LEVEL;
		end
	end

	// ***************************************
	// Receive shifter
	// ***************************************
	spmh_byte_t rsh_q, rsh_d, rdat_q, rdat_d;
	logic [3:0] rcnt_q, rcnt_d;
	logic       rvld_q, rvld_d;
	always_comb
	begin
		rsh_d  = rsh_q;
		rcnt_d = rcnt_q;
		rdat_d = rdat_q;
		rvld_d = 1'b0;
		if (!dcd_s)
			rcnt_d = 4'h0;
		else if (rxc_fall)
		begin
			rsh_d = {rxd_s, rsh_q[SPMH_DATA_W-1:1]};
			if (rcnt_q == 4'(SPMH_DATA_W - 1))
			begin
				rdat_d = {rxd_s, rsh_q[SPMH_DATA_W-1:1]};
				rvld_d = 1'b1;
				rcnt_d = 4'h0;
			end
			else
				rcnt_d = rcnt_q + 4'h1;
		end
	end

	// ***************************************
	// Pin and status outputs
	// ***************************************
	logic tclk_d, toe_d, rts_d, dtr_d, ok_d;
	always_comb
	begin
		rts_d  = cfg.rts_req;
		dtr_d  = cfg.dtr_req;
		ok_d   = cts_s && dsr_s && cfg.rts_req && cfg.dtr_req;
		toe_d  = cfg.sync_mode;
		if (!cfg.sync_mode)
			tclk_d = 1'b0;
		else if (cfg.local_clk)
			tclk_d = lclk_d;
		else
			tclk_d = txc_s;
		if (st_q == SPMH_TX_SHIFT || (st_q == SPMH_TX_IDLE && b_ready))
			rts_d = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= SPMH_DIV_RESET;
			lclk_q <= 1'b0;
			st_q <= SPMH_TX_IDLE;
			sh_q <= '0;
			bit_q <= 4'h0;
			txd_q <= SPMH_IDLE_LEVEL;
			rsh_q <= '0;
			rcnt_q <= 4'h0;
			rdat_q <= '0;
			rvld_q <= 1'b0;
			dte_terminal_clock <= 1'b0;
			dte_terminal_clock_oe <= 1'b0;
			rts <= 1'b0;
			dtr <= 1'b0;
			link_ok <= 1'b0;
			hs_status <= '0;
		end
		else
		begin
			div_q <= div_d;
			lclk_q <= lclk_d;
			st_q <= st_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			txd_q <= txd_d;
			rsh_q <= rsh_d;
			rcnt_q <= rcnt_d;
			rdat_q <= rdat_d;
			rvld_q <= rvld_d;
			dte_terminal_clock <= tclk_d;
			dte_terminal_clock_oe <= toe_d;
			rts <= rts_d;
			dtr <= dtr_d;
			link_ok <= ok_d;
			hs_status <= '{cts: cts_s, dsr: dsr_s, dcd: dcd_s};
		end
	end

	assign txd     = txd_q;
	assign rx_valid = rvld_q;
	assign rx_data  = rdat_q;

	// ***************************************
	// Checks
	// ***************************************
	AST_TXD_IDLE_NO_CTS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == SPMH_TX_IDLE && !cts_s && !cfg.ctrl_send) |=> txd)
		else $error("txd left idle level without clear to send");
	AST_START_NEEDS_HS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == SPMH_TX_IDLE && st_d == SPMH_TX_SHIFT) |-> (may_send && cfg.sync_mode))
		else $error("transmit started without handshake");
	AST_BIT_ON_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == SPMH_TX_SHIFT && !bit_edge) |=> $stable(txd))
		else $error("txd changed without a bit edge");
	AST_ECHO_CLK: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cfg.sync_mode && !cfg.local_clk) |=> (dte_terminal_clock == $past(txc_s)))
		else $error("terminal clock does not echo modem clock");
	AST_ASYNC_STATIC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cfg.sync_mode |=> (!dte_terminal_clock && !dte_terminal_clock_oe))
		else $error("terminal clock active in async mode");
	AST_RX_BYTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rvld_q |-> $past(rxc_fall))
		else $error("byte delivered without rx clock fall");
	AST_DTR_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg.dtr_req |=> dtr)
		else $error("dtr not following request");
	AST_RTS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_q == SPMH_TX_SHIFT) |=> rts)
		else $error("rts dropped mid character");
	AST_LOCAL_ONLY_SYNC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!cfg.sync_mode || !cfg.local_clk) |=> (div_q == SPMH_DIV_RESET))
		else $error("local clock running when not requested");
endmodule

// ==== spmh_dce_model.sv ====
// Modem-side partner: handshake lines, link clocks and serial data
module spmh_dce_model
(
	// Terminal side
	input  wire logic txd,
	input  wire logic dte_terminal_clock,
	// Modem side
	output logic        cts,
	output logic        dsr,
	output logic        dcd,
	output logic        rxd,
	output logic        dce_tx_clock,
	output logic        dce_rx_clock,
	// Captured terminal lines
	output logic [15:0] cap_q,
	output logic [15:0] echo_q
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		{cts, dsr, dcd, dce_tx_clock, dce_rx_clock} = 5'h00;
		rxd = 1'b1;
		cap_q = 16'h0000;
		echo_q = 16'h0000;
	end
	// Clear, ready and carrier levels
	task automatic hs(input logic [2:0] v);
		{cts, dsr, dcd} = v;
	endtask
	// Transmit clock frame, txd caught before each fall
	task automatic tx_run(input int n);
		#1.3;
		repeat (n)
		begin
			dce_tx_clock = 1'b1;
			#22;
			cap_q = {txd, cap_q[15:1]};
			echo_q = {dte_terminal_clock, echo_q[15:1]};
			#2;
			dce_tx_clock = 1'b0;
			#24;
		end
	endtask
	// One received byte, LSB first, fall at bit centre
	task automatic rx_send(input logic [7:0] b);
		#1.3;
		for (int i = 0; i < 8; i++)
		begin
			rxd = b[i];
			dce_rx_clock = 1'b1;
			#24;
			dce_rx_clock = 1'b0;
			#24;
		end
		rxd = ~rxd;
	endtask
endmodule

// ==== spmh_port_test.sv ====
// Self-checking bench for the serial port handshake block
module spmh_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	import spmh_pkg::*;
	// ****************
	// Signals
	// ****************
	logic         clk_sys, rst_n, tx_valid, tx_ready, rx_valid, link_ok, txd, rxd, rts, dtr;
	logic         cts, dsr, dcd, dce_tx_clock, dce_rx_clock;
	logic         dte_terminal_clock, dte_terminal_clock_oe;
	logic [15:0]  cap_q, echo_q;
	spmh_cfg_t    cfg;
	spmh_byte_t   tx_data, rx_data, got;
	spmh_dce_hs_t hs_status;
	int           error_cnt, n_checks, nrx;

	spmh_port spmh_port_inst (.clk_sys, .rst_n, .cfg, .tx_valid, .tx_ready, .tx_data,
		.rx_valid, .rx_data, .hs_status, .link_ok, .txd, .rxd, .rts, .dtr, .cts, .dsr, .dcd,
		.dce_tx_clock, .dce_rx_clock, .dte_terminal_clock, .dte_terminal_clock_oe);
	spmh_dce_model spmh_dce_model_inst (.txd, .dte_terminal_clock, .cts, .dsr, .dcd, .rxd,
		.dce_tx_clock, .dce_rx_clock, .cap_q, .echo_q);

	initial
	begin
		clk_sys = 1'b0;
		forever
			#2 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys)
		if (rx_valid === 1'b1)
		begin
			got <= rx_data;
			nrx <= nrx + 1;
		end
	// ****************
	// Helpers
	// ****************
	task automatic chk(input logic [15:0] act, input logic [15:0] exp, input string m);
		n_checks++;
		if (act !== exp)
		begin
			error_cnt++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic run(input int n);
		spmh_dce_model_inst.tx_run(n);
	endtask
	// Mode bits: sync, local, request, terminal ready, control
	task automatic setm(input logic [4:0] m, input logic [2:0] v);
		@(negedge clk_sys);
		cfg = spmh_cfg_t'({m, 16'h0003});
		spmh_dce_model_inst.hs(v);
		wt(5);
	endtask
	task automatic push(input spmh_byte_t b, output bit ok);
		@(negedge clk_sys);
		ok = tx_ready;
		if (ok)
		begin
			tx_valid = 1'b1;
			tx_data = b;
			@(negedge clk_sys);
			tx_valid = 1'b0;
		end
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_gate(input logic [2:0] v, input logic c, input spmh_byte_t b);
		bit ok;
		setm({4'b1011, c}, v);
		chk(hs_status, v, "status");
		chk({link_ok, rts, dtr}, {v[2] & v[1], 2'b11}, "lines");
		push(b, ok);
		run(9);
		chk(cap_q[15:7], c ? {1'b1, b} : 9'h1FF, "gated");
		if (!c)
		begin
			setm(5'b10110, 3'b111);
			run(9);
			chk(cap_q[15:7], {1'b1, b}, "open");
		end
		$display("gate test done");
	endtask
	task automatic t_drop();
		bit ok;
		setm(5'b10110, 3'b111);
		push(8'hC5, ok);
		run(3);
		setm(5'b10010, 3'b111);
		chk(rts, 1'b1, "rts held");
		run(6);
		chk(cap_q[15:7], 9'h1C5, "finish");
		run(2);
		wt(5);
		chk(rts, 1'b0, "rts off");
		$display("drop test done");
	endtask
	task automatic t_buf();
		bit ok;
		int n;
		setm(5'b10110, 3'b110);
		n = 0;
		ok = 1'b1;
		while (ok && n < 6)
		begin
			push(8'h81 >> n, ok);
			n += ok;
		end
		chk(16'(n >= SPMH_BUF_DEPTH && n < 6), 16'h0001, "fill");
		setm(5'b10110, 3'b111);
		for (int k = 0; k < n; k++)
		begin
			run(9);
			chk(cap_q[15:7], {1'b1, 8'h81 >> k}, "drain");
		end
		chk({tx_ready, txd}, 2'b11, "empty");
		$display("buffer test done");
	endtask
	task automatic t_rx();
		int n0;
		setm(5'b10110, 3'b111);
		n0 = nrx;
		spmh_dce_model_inst.rx_send(8'hA6);
		wt(8);
		chk(got, 8'hA6, "rx first");
		spmh_dce_model_inst.rx_send(8'h35);
		wt(8);
		setm(5'b10110, 3'b110);
		spmh_dce_model_inst.rx_send(8'hFF);
		wt(8);
		setm(5'b00110, 3'b111);
		spmh_dce_model_inst.rx_send(8'h0F);
		wt(8);
		chk({8'(nrx - n0), got}, 16'h0235, "rx count");
		$display("receive test done");
	endtask
	task automatic t_clk();
		int n;
		logic p;
		setm(5'b00110, 3'b111);
		run(4);
		chk({dte_terminal_clock_oe, echo_q[15:12] inside {4'h0, 4'hF}}, 2'b01, "async");
		setm(5'b10110, 3'b111);
		run(4);
		chk({dte_terminal_clock_oe, echo_q[15:12]}, 5'h1F, "echo");
		setm(5'b11110, 3'b111);
		n = 0;
		p = dte_terminal_clock;
		repeat (80)
		begin
			@(negedge clk_sys);
			n += (dte_terminal_clock === 1'b1 && p === 1'b0);
			p = dte_terminal_clock;
		end
		chk(16'(n), 16'd80 / (16'd2 * (16'h0003 + 16'd1)), "local rate");
		$display("clock test done");
	endtask
	// ****************
	// Main sequence
	// ****************
	initial
	begin
		rst_n = 1'b0;
		cfg = '0;
		tx_valid = 1'b0;
		tx_data = '0;
		nrx = 0;
		error_cnt = 0;
		n_checks = 0;
		wt(6);
		chk({txd, rts, dtr, dte_terminal_clock_oe, rx_valid}, 5'h10, "reset");
		rst_n = 1'b1;
		wt(2);
		t_gate(3'b110, 1'b0, 8'hA5);
		t_gate(3'b011, 1'b0, 8'h5A);
		t_gate(3'b100, 1'b0, 8'h96);
		t_gate(3'b100, 1'b1, 8'h69);
		t_drop();
		t_buf();
		t_rx();
		t_clk();
		complete_run();
	end
	initial
	begin
		#300000;
		error_cnt++;
		$display("mismatch %0t timed out", $time);
		complete_run();
	end
endmodule
